// File: nfs_consts.svh
// Purpose: Offsets, field positions, codes and counts of the NVM sequencer
// Assumes: 32-bit classic Wishbone, word aligned registers
// Notes: Included by the package file only; the sequencer uses its macros
`ifndef NFS_CONSTS_SVH
`define NFS_CONSTS_SVH

// Register byte offsets
`define NFS_OFS_CMD 5'h00
`define NFS_OFS_CONTROL_REG_A 5'h04
`define NFS_OFS_STATUS 5'h08
`define NFS_OFS_FIRST_DATA_BYTE_REG 5'h0C
`define NFS_OFS_ADDR 5'h10
`define NFS_OFS_CCP 5'h14
`define NFS_OFS_LOCK 5'h18

// Field positions
`define NFS_EXEC_BIT 0
`define NFS_BUSY_BIT 0
`define NFS_FLASH_SECTION_BUSY_FLAG_BIT 1

// Reset and erase values
`define NFS_LOCK_RST 8'hFF
`define NFS_ERASED_WORD 16'hFFFF

// Command codes
`define NFS_CMD_NOP 7'h00
`define NFS_CMD_RD_USR 7'h01
`define NFS_CMD_RD_CAL 7'h02
`define NFS_CMD_RD_FUSE 7'h07
`define NFS_CMD_WR_LOCK 7'h08
`define NFS_CMD_USR_ERASE 7'h18
`define NFS_CMD_USR_WRITE 7'h1A
`define NFS_CMD_APP_ERASE 7'h20
`define NFS_CMD_APP_PG_ER 7'h22
`define NFS_CMD_LOAD_BUF 7'h23
`define NFS_CMD_APP_PG_WR 7'h24
`define NFS_CMD_APP_PG_EW 7'h25
`define NFS_CMD_ERASE_BUF 7'h26
`define NFS_CMD_BOOT_PG_ER 7'h2A
`define NFS_CMD_PG_ER 7'h2B
`define NFS_CMD_BOOT_PG_WR 7'h2C
`define NFS_CMD_BOOT_PG_EW 7'h2D
`define NFS_CMD_PG_WR 7'h2E
`define NFS_CMD_PG_EW 7'h2F

// Change protection key and window
`define NFS_CCP_KEY 8'h9D
`define NFS_CCP_CYCLES 3'd4

// Pointer layout: byte select bit 0, word bits [6:1], page bits [15:7]
`define NFS_WORD_LSB 1
`define NFS_PAGE_LSB 7
`define NFS_PAGE_W 9
`define NFS_WORD_W 6

`endif

// File: nfs_flash_model.sv
// Purpose: Flash array stand-in facing the sequencer request port
// Assumes: One request at a time; buffer word lags its index by a cycle
// Notes: Keeps the last buffer image it read for the bench to inspect
`timescale 1ns/10ps
module nfs_flash_model (
	// Clock
	input wire logic core_clk_i,
	// Request and page buffer
	input wire nfs_pkg::nfs_flash_req_t req_i,
	input wire logic [15:0] buf_word_i,
	input wire logic [31:0] dly_i,
	output logic done_o,
	output logic [5:0] idx_o
);
	import nfs_pkg::*;
	logic [15:0] cap [64];
	////////////////////////////////////////
	// Walk the whole buffer, then answer dly_i cycles late
	initial begin
		done_o = 1'b0;
		idx_o = 6'h00;
		forever begin
			@(posedge core_clk_i);
			if (req_i.req === 1'b1) begin
				for (int i = 0; i < 66 + dly_i; i++) begin
					@(posedge core_clk_i);
					idx_o <= 6'(i);
					if (i > 1 && i < 66)
						cap[i-2] = buf_word_i;
				end
				done_o <= 1'b1;
				@(posedge core_clk_i);
				done_o <= 1'b0;
				idx_o <= ~idx_o; // Index not held after the walk
			end
		end
	end
endmodule

// File: nfs_pkg.sv
// Purpose: Types shared by the NVM sequencer and its users
// Assumes: Constants come from nfs_consts.svh
// Notes: States are one-hot
`include "nfs_consts.svh"
package nfs_pkg;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_BUF_ERASE = 6'b00_0010,
		ST_FLASH = 6'b00_0100,
		ST_USR_CLR = 6'b00_1000,
		ST_FUSE = 6'b01_0000,
		ST_LOCK = 6'b10_0000
	} nfs_state_t;

	typedef enum logic [2:0] {
		OP_PG_ERASE = 3'h0,
		OP_PG_WRITE = 3'h1,
		OP_PG_ERWR = 3'h2,
		OP_APP_ERASE = 3'h3,
		OP_USR_ERASE = 3'h4,
		OP_USR_WRITE = 3'h5
	} nfs_op_t;

	// Request to the flash array
	typedef struct packed {
		logic req;
		nfs_op_t op;
		logic [`NFS_PAGE_W-1:0] page;
	} nfs_flash_req_t;

	// All control state of the sequencer
	typedef struct packed {
		nfs_state_t st;
		logic [6:0] cmd;
		logic exec;
		logic [7:0] first_data_byte_reg;
		logic [7:0] addr;
		logic [2:0] ccp_cnt;
		logic ack;
		logic [31:0] dat;
		logic [7:0] lock;
		nfs_flash_req_t freq;
		logic halt;
		logic flash_section_busy_flag;
		logic [`NFS_WORD_W-1:0] cnt;
		logic [7:0] lpm_data;
		logic lpm_vld;
		logic ee_clr;
	} nfs_regs_t;

endpackage

// File: nfs_seq.sv
// Purpose: Self-programming command sequencer of the flash controller
// Assumes: CPU strobes are one-cycle pulses synchronous to core_clk_i
// Notes: Flash array sits outside; it reads the page buffer and acks ops
`timescale 1ns/10ps
module nfs_seq #(
	parameter logic [`NFS_PAGE_W-1:0] BOOT_PAGE = 9'h1C0
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// CPU program memory instructions
	input wire logic spm_i,
	input wire logic lpm_i,
	input wire logic [15:0] ptr_i,
	input wire logic [15:0] word_i,
	output logic [7:0] lpm_data_o,
	output logic lpm_valid_o,
	output logic cpu_halt_o,
	// Row, flash and fuse read sources
	input wire logic [15:0] flash_word_i,
	input wire logic [7:0] usr_byte_i,
	input wire logic [7:0] cal_byte_i,
	input wire logic [7:0] fuse_byte_i,
	output logic [15:0] rd_addr_o,
	output logic [7:0] fuse_addr_o,
	// Flash array side
	output nfs_pkg::nfs_flash_req_t flash_req_o,
	input wire logic flash_done_i,
	input wire logic [`NFS_WORD_W-1:0] buf_idx_i,
	output logic [15:0] buf_word_o,
	// Status
	output logic busy_o,
	output logic flash_section_busy_flag_o,
	output logic app_rd_block_o,
	output logic ee_buf_erase_o,
	output logic [7:0] lock_o
);
	import nfs_pkg::*;

	localparam int WORDS = 1 << `NFS_WORD_W;

	nfs_regs_t r_ff;
	nfs_regs_t nxt_r;
	logic [15:0] buf_ff [WORDS];
	logic [15:0] buf_rd_ff;

	////////////////////////////////////////////////////////////////////
	// Helpers
	////////////////////////////////////////////////////////////////////

	// Page part of the pointer only; word and byte bits dropped
	function automatic logic [`NFS_PAGE_W-1:0] page_of(logic [15:0] p);
		return p[15:`NFS_PAGE_LSB];
	endfunction

	function automatic logic in_app(logic [15:0] p);
		return page_of(p) < BOOT_PAGE;
	endfunction

	// Byte pick from a word by pointer bit 0
	function automatic logic [7:0] pick(logic [15:0] w, logic b);
		return b ? w[15:8] : w[7:0];
	endfunction

	logic idle;
	logic ccp_open;
	logic wr_hit;
	logic rd_go;
	logic buf_load;
	logic [7:0] wb_be;
	assign idle = (r_ff.st == ST_IDLE);
	assign ccp_open = (r_ff.ccp_cnt != 3'd0);
	// Write lands at the edge where ack is seen
	assign wr_hit = cyc_i && stb_i && we_i && r_ff.ack;
	assign rd_go = cyc_i && stb_i && !r_ff.ack;
	// Buffer load needs no protection window
	assign buf_load = spm_i && idle && (r_ff.cmd == `NFS_CMD_LOAD_BUF);
	assign wb_be = dat_i[7:0];

	////////////////////////////////////////////////////////////////////
	// Next state
	////////////////////////////////////////////////////////////////////

	// All control decisions in one place
	always_comb begin
		nxt_r = r_ff;
		nxt_r.ack = rd_go;
		nxt_r.freq.req = 1'b0;
		nxt_r.ee_clr = 1'b0;
		nxt_r.lpm_vld = 1'b0;
		if (ccp_open) begin
			nxt_r.ccp_cnt = r_ff.ccp_cnt - 3'd1;
		end
		// Register read data, held through ack
		if (rd_go) begin
			nxt_r.dat = 32'h0000_0000;
			case (adr_i)
				`NFS_OFS_CMD: nxt_r.dat[6:0] = r_ff.cmd;
				`NFS_OFS_CONTROL_REG_A: nxt_r.dat[`NFS_EXEC_BIT] = r_ff.exec;
				`NFS_OFS_STATUS: begin
					nxt_r.dat[`NFS_BUSY_BIT] = !idle;
					nxt_r.dat[`NFS_FLASH_SECTION_BUSY_FLAG_BIT] = r_ff.flash_section_busy_flag;
				end
				`NFS_OFS_FIRST_DATA_BYTE_REG: nxt_r.dat[7:0] = r_ff.first_data_byte_reg;
				`NFS_OFS_ADDR: nxt_r.dat[7:0] = r_ff.addr;
				`NFS_OFS_LOCK: nxt_r.dat[7:0] = r_ff.lock;
				default: nxt_r.dat = 32'h0000_0000;
			endcase
		end
		// Register writes; low byte lane carries all fields
		if (wr_hit && sel_i[0]) begin
			case (adr_i)
				`NFS_OFS_CMD: nxt_r.cmd = dat_i[6:0];
				`NFS_OFS_CONTROL_REG_A: begin
					// Execute counts only inside the protection window; read fuses is taken below
					if (wb_be[`NFS_EXEC_BIT] && idle && ccp_open) begin
						nxt_r.exec = 1'b1;
					end
				end
				`NFS_OFS_FIRST_DATA_BYTE_REG: nxt_r.first_data_byte_reg = wb_be;
				`NFS_OFS_ADDR: nxt_r.addr = wb_be;
				`NFS_OFS_CCP: begin
					if (wb_be == `NFS_CCP_KEY) begin
						nxt_r.ccp_cnt = `NFS_CCP_CYCLES;
					end
				end
				default: ;
			endcase
		end
		// Read fuses is unprotected, so it may start outside the window
		if (wr_hit && sel_i[0] && adr_i == `NFS_OFS_CONTROL_REG_A && idle &&
			wb_be[`NFS_EXEC_BIT] && r_ff.cmd == `NFS_CMD_RD_FUSE) begin
			nxt_r.exec = 1'b1;
		end
		// Load instruction: row or flash byte, answered next cycle
		if (lpm_i) begin
			nxt_r.lpm_vld = 1'b1;
			case (r_ff.cmd)
				`NFS_CMD_RD_USR: nxt_r.lpm_data = usr_byte_i;
				`NFS_CMD_RD_CAL: nxt_r.lpm_data = cal_byte_i;
				default: begin
					if (r_ff.flash_section_busy_flag && in_app(ptr_i)) begin
						nxt_r.lpm_data = 8'hFF;
					end else begin
						nxt_r.lpm_data = pick(flash_word_i, ptr_i[0]);
					end
				end
			endcase
		end
		case (r_ff.st)
			ST_IDLE: begin
				// Action commands, one cycle after execute is stored
				if (r_ff.exec) begin
					nxt_r.exec = 1'b0;
					case (r_ff.cmd)
						`NFS_CMD_ERASE_BUF: begin
							nxt_r.cnt = '0;
							nxt_r.st = ST_BUF_ERASE;
						end
						`NFS_CMD_RD_FUSE: begin
							nxt_r.halt = 1'b1;
							nxt_r.st = ST_FUSE;
						end
						`NFS_CMD_WR_LOCK: begin
							nxt_r.halt = 1'b1;
							nxt_r.st = ST_LOCK;
						end
						default: ;
					endcase
				end else if (spm_i && ccp_open) begin
					// Store-triggered flash commands, address latched
					nxt_r.freq.page = page_of(ptr_i);
					nxt_r.freq.req = 1'b1;
					nxt_r.flash_section_busy_flag = 1'b1;
					nxt_r.halt = !in_app(ptr_i);
					nxt_r.st = ST_FLASH;
					case (r_ff.cmd)
						`NFS_CMD_PG_ER: nxt_r.freq.op = OP_PG_ERASE;
						`NFS_CMD_PG_WR: nxt_r.freq.op = OP_PG_WRITE;
						`NFS_CMD_PG_EW: nxt_r.freq.op = OP_PG_ERWR;
						`NFS_CMD_APP_ERASE: begin
							nxt_r.freq.op = OP_APP_ERASE;
							nxt_r.halt = 1'b1;
							if (!in_app(ptr_i)) begin
								nxt_r.st = ST_IDLE;
							end
						end
						`NFS_CMD_APP_PG_ER, `NFS_CMD_APP_PG_WR,
						`NFS_CMD_APP_PG_EW: begin
							nxt_r.freq.op = (r_ff.cmd == `NFS_CMD_APP_PG_ER) ?
								OP_PG_ERASE : (r_ff.cmd == `NFS_CMD_APP_PG_WR) ?
								OP_PG_WRITE : OP_PG_ERWR;
							if (!in_app(ptr_i)) begin
								nxt_r.st = ST_IDLE;
							end
						end
						`NFS_CMD_BOOT_PG_ER, `NFS_CMD_BOOT_PG_WR,
						`NFS_CMD_BOOT_PG_EW: begin
							nxt_r.freq.op = (r_ff.cmd == `NFS_CMD_BOOT_PG_ER) ?
								OP_PG_ERASE : (r_ff.cmd == `NFS_CMD_BOOT_PG_WR) ?
								OP_PG_WRITE : OP_PG_ERWR;
							if (in_app(ptr_i)) begin
								nxt_r.st = ST_IDLE;
							end
						end
						`NFS_CMD_USR_ERASE: begin
							nxt_r.freq.op = OP_USR_ERASE;
							nxt_r.flash_section_busy_flag = 1'b0;
							nxt_r.halt = 1'b1;
						end
						`NFS_CMD_USR_WRITE: begin
							nxt_r.freq.op = OP_USR_WRITE;
							nxt_r.flash_section_busy_flag = 1'b0;
							nxt_r.halt = 1'b1;
						end
						default: nxt_r.st = ST_IDLE;
					endcase
					// Aborted or unknown: nothing issued
					if (nxt_r.st == ST_IDLE) begin
						nxt_r.freq.req = 1'b0;
						nxt_r.flash_section_busy_flag = 1'b0;
						nxt_r.halt = 1'b0;
					end
				end
			end
			ST_BUF_ERASE: begin
				// One location per cycle, busy until the last
				nxt_r.cnt = r_ff.cnt + 1'b1;
				if (r_ff.cnt == `NFS_WORD_W'(WORDS - 1)) begin
					nxt_r.halt = 1'b0;
					nxt_r.st = ST_IDLE;
				end
			end
			ST_FLASH: begin
				// Array op runs to completion; no abort path
				if (flash_done_i) begin
					nxt_r.flash_section_busy_flag = 1'b0;
					nxt_r.halt = 1'b0;
					nxt_r.cnt = '0;
					nxt_r.st = (r_ff.freq.op == OP_USR_WRITE) ?
						ST_USR_CLR : ST_IDLE;
				end
			end
			ST_USR_CLR: begin
				// Buffer clear after user row write, CPU running
				nxt_r.cnt = r_ff.cnt + 1'b1;
				if (r_ff.cnt == `NFS_WORD_W'(WORDS - 1)) begin
					nxt_r.st = ST_IDLE;
				end
			end
			ST_FUSE: begin
				nxt_r.first_data_byte_reg = fuse_byte_i;
				nxt_r.halt = 1'b0;
				nxt_r.st = ST_IDLE;
			end
			ST_LOCK: begin
				// Programmed bits are zero; ones can only be cleared
				nxt_r.lock = r_ff.lock & r_ff.first_data_byte_reg;
				nxt_r.ee_clr = 1'b1;
				nxt_r.cnt = '0;
				nxt_r.st = ST_BUF_ERASE;
			end
			default: nxt_r.st = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r_ff <= '{st: ST_IDLE, freq: '{req: 1'b0, op: OP_PG_ERASE,
				page: '0}, lock: `NFS_LOCK_RST, default: '0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Page buffer
	////////////////////////////////////////////////////////////////////

	// Memory kept out of reset; erased by the sequencer walk
	always_ff @(posedge core_clk_i) begin
		if (r_ff.st == ST_BUF_ERASE || r_ff.st == ST_USR_CLR) begin
			buf_ff[r_ff.cnt] <= `NFS_ERASED_WORD;
		end else if (buf_load) begin
			buf_ff[ptr_i[`NFS_PAGE_LSB-1:`NFS_WORD_LSB]] <= word_i;
		end
		buf_rd_ff <= buf_ff[buf_idx_i];
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	////////////////////////////////////////////////////////////////////

	assign dat_o = r_ff.dat;
	assign ack_o = r_ff.ack;
	assign lpm_data_o = r_ff.lpm_data;
	assign lpm_valid_o = r_ff.lpm_vld;
	assign cpu_halt_o = r_ff.halt;
	assign rd_addr_o = ptr_i;
	assign fuse_addr_o = r_ff.addr;
	assign flash_req_o = r_ff.freq;
	assign buf_word_o = buf_rd_ff;
	assign busy_o = !idle;
	assign flash_section_busy_flag_o = r_ff.flash_section_busy_flag;
	assign app_rd_block_o = r_ff.flash_section_busy_flag;
	assign ee_buf_erase_o = r_ff.ee_clr;
	assign lock_o = r_ff.lock;

	////////////////////////////////////////////////////////////////////
	// Checks
	////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_lock_go;
		r_ff.st == ST_LOCK;
	endsequence

	sequence s_buf_walk;
		ee_buf_erase_o && r_ff.st == ST_BUF_ERASE;
	endsequence

	a_exec_self_clear: assert property (r_ff.exec |=> !r_ff.exec)
		else $error("execute bit did not clear");
	a_buf_erase_busy: assert property ((r_ff.st == ST_BUF_ERASE &&
		r_ff.cnt != 6'h3F) |=> busy_o && r_ff.st == ST_BUF_ERASE)
		else $error("busy dropped before buffer erased");
	a_load_word: assert property (buf_load && !(r_ff.st == ST_BUF_ERASE)
		|=> buf_ff[$past(ptr_i[6:1])] == $past(word_i))
		else $error("buffer word not loaded");
	a_flash_block: assert property ((r_ff.st == ST_FLASH && r_ff.flash_section_busy_flag)
		|-> app_rd_block_o && busy_o)
		else $error("app reads not blocked during flash op");
	a_app_erase_halt: assert property ((r_ff.st == ST_FLASH &&
		r_ff.freq.op == OP_APP_ERASE) |-> cpu_halt_o)
		else $error("cpu runs during app erase");
	a_bad_section: assert property ((idle && spm_i && ccp_open &&
		(r_ff.cmd == `NFS_CMD_APP_PG_ER || r_ff.cmd == `NFS_CMD_APP_PG_WR)
		&& !in_app(ptr_i))
		|=> idle && !flash_req_o.req)
		else $error("wrong section command not aborted");
	a_lock_secure: assert property ((r_ff.lock & ~$past(r_ff.lock)) == 8'h00)
		else $error("lock bit moved to less secure");
	a_fuse_data: assert property (r_ff.st == ST_FUSE |=>
		r_ff.first_data_byte_reg == $past(fuse_byte_i) && !cpu_halt_o)
		else $error("fuse byte not captured");
	a_usr_clr_run: assert property (r_ff.st == ST_USR_CLR |->
		busy_o && !cpu_halt_o)
		else $error("user row clear stage wrong");
	a_lock_clears: assert property (s_lock_go |=> s_buf_walk)
		else $error("lock write did not erase buffers");

endmodule

// File: nfs_seq_bench.sv
// Purpose: Self-checking bench of the flash command sequencer
// Assumes: Flash model answers each operation after a set delay
// Notes: Each t_ test task drives its scenarios and judges them before returning; wb, exec and spm_go drive and check only that ack came
`timescale 1ns/10ps
module nvm_flash_self_program_seq_bench;
	import nfs_pkg::*;
	logic clk, rst_b, cyc, stb, we, ack, program_store_instruction, program_load_instruction, done, saw_h, saw_ee;
	logic lval, halt, busy, flash_section_busy_flag, blk, ee;
	logic [4:0] adr;
	logic [5:0] idx;
	logic [7:0] lbyte, faddr, lock, ub, cb, fb;
	logic [15:0] ptr, word, raddr, bword, fword;
	logic [31:0] wdat, rdat, q, dly;
	nfs_flash_req_t freq;
	int bad_count, n_checks, n;
	// Sources echo the address, so a wrong address shows up
	assign fword = {raddr[7:0] ^ 8'hA5, raddr[7:0]};
	assign ub = raddr[7:0] ^ 8'h5A;
	assign cb = raddr[7:0] + 8'h01;
	assign fb = faddr ^ 8'h3C;
	// Section table; op 7 means the command must be refused
	logic [6:0] tc [13] = '{7'h22, 7'h22, 7'h2A, 7'h2A, 7'h24, 7'h25,
		7'h2D, 7'h2C, 7'h2B, 7'h20, 7'h20, 7'h18, 7'h1A};
	logic [8:0] tp [13] = '{9'h010, 9'h1C0, 9'h010, 9'h1C1, 9'h011,
		9'h012, 9'h1C2, 9'h013, 9'h1FF, 9'h0A0, 9'h1C0, 9'h000, 9'h000};
	logic [2:0] to [13] = '{3'h0, 3'h7, 3'h7, 3'h0, 3'h1, 3'h2, 3'h2,
		3'h7, 3'h0, 3'h3, 3'h7, 3'h4, 3'h5};

	nfs_seq dut (.core_clk_i(clk), .rst_b_i(rst_b), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat),
		.dat_o(rdat), .ack_o(ack), .spm_i(program_store_instruction), .lpm_i(program_load_instruction), .ptr_i(ptr),
		.word_i(word), .lpm_data_o(lbyte), .lpm_valid_o(lval),
		.cpu_halt_o(halt), .flash_word_i(fword), .usr_byte_i(ub),
		.cal_byte_i(cb), .fuse_byte_i(fb), .rd_addr_o(raddr),
		.fuse_addr_o(faddr), .flash_req_o(freq), .flash_done_i(done),
		.buf_idx_i(idx), .buf_word_o(bword), .busy_o(busy),
		.flash_section_busy_flag_o(flash_section_busy_flag), .app_rd_block_o(blk), .ee_buf_erase_o(ee),
		.lock_o(lock));
	nfs_flash_model fm (.core_clk_i(clk), .req_i(freq),
		.buf_word_i(bword), .dly_i(dly), .done_o(done), .idx_o(idx));
	////////////////////////////////////////
	// Short pulses are caught here rather than by polling tasks
	always @(posedge clk) begin
		if (halt === 1'b1) saw_h <= 1'b1;
		if (ee === 1'b1) saw_ee <= 1'b1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Classic cycle: hold until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			t++;
		end while (ack !== 1'b1 && t < 20);
		q = rdat;
		chk(t < 20, 1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic exec(input logic [6:0] c, input logic p);
		wb(1, `NFS_OFS_CMD, 32'(c));
		if (p) wb(1, `NFS_OFS_CCP, 32'(`NFS_CCP_KEY));
		wb(1, `NFS_OFS_CONTROL_REG_A, 32'h0000_0001);
		// State moves one edge after execute is stored; let it show
		@(posedge clk);
	endtask

	// Leaves at the edge after the store; answers stand in that cycle
	task automatic spm_go(input logic [15:0] p, input logic [6:0] c,
		input logic prot);
		wb(1, `NFS_OFS_CMD, 32'(c));
		if (prot) wb(1, `NFS_OFS_CCP, 32'(`NFS_CCP_KEY));
		ptr <= p;
		program_store_instruction <= 1'b1;
		@(posedge clk);
		program_store_instruction <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wait_idle(output int k);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (busy !== 1'b0 && k < 500);
		chk(k < 500, 1);
	endtask
	////////////////////////////////////////
	task automatic t_regs();
		wb(0, `NFS_OFS_STATUS, 0);
		chk(q, 0);
		wb(1, `NFS_OFS_LOCK, 0);
		wb(0, `NFS_OFS_LOCK, 0);
		chk(q, 32'h0000_00FF); // Read only, resets unlocked
		wb(1, `NFS_OFS_CMD, 32'hFFFF_FFFF);
		wb(0, `NFS_OFS_CMD, 0);
		chk(q, 32'h0000_007F);
		wb(0, 5'h1C, 0);
		chk(q, 0);
	endtask

	task automatic t_buf_erase();
		exec(7'h26, 0);
		chk(busy, 0);
		exec(7'h26, 1);
		chk(busy, 1);
		wait_idle(n);
		chk(n >= 62 && n <= 66, 1);
	endtask

	task automatic t_load_write();
		wb(1, `NFS_OFS_CMD, 32'h0000_0023);
		for (int i = 1; i < 4; i++) begin
			ptr <= {9'h1FF, 6'(i), 1'b1};
			word <= 16'h1230 + 16'(i);
			program_store_instruction <= 1'b1;
			@(posedge clk);
			program_store_instruction <= 1'b0;
			@(posedge clk);
		end
		chk(busy, 0);
		spm_go(16'h02FF, 7'h2E, 0);
		chk(freq.req, 0);
		@(posedge clk);
		dly = 3;
		spm_go(16'h02FF, 7'h2E, 1);
		chk(freq, {1'b1, OP_PG_WRITE, 9'h005});
		chk({busy, flash_section_busy_flag, blk, halt}, 4'b1110);
		@(posedge clk);
		ptr <= 16'hFF81; // Pointer moves while the write runs
		wait_idle(n);
		for (int i = 0; i < 5; i++)
			chk(fm.cap[i], (i > 0 && i < 4) ? 16'h1230 + i : 16'hFFFF);
	endtask

	task automatic t_fuse_lock();
		wb(1, `NFS_OFS_ADDR, 32'h0000_0003);
		saw_h = 1'b0;
		exec(7'h07, 0);
		wait_idle(n);
		wb(0, `NFS_OFS_FIRST_DATA_BYTE_REG, 0);
		chk({saw_h, q}, {1'b1, 32'h0000_003F});
		wb(1, `NFS_OFS_FIRST_DATA_BYTE_REG, 32'h0000_00F3);
		exec(7'h08, 0);
		chk(busy, 0);
		saw_ee = 1'b0;
		exec(7'h08, 1);
		chk(busy, 1);
		wait_idle(n);
		chk({saw_h, saw_ee, lock}, {2'b11, 8'hF3});
		wb(1, `NFS_OFS_FIRST_DATA_BYTE_REG, 32'h0000_00FE);
		exec(7'h08, 1);
		wait_idle(n);
		chk(lock, 8'hF2);
		wb(0, `NFS_OFS_CONTROL_REG_A, 0);
		chk(q, 0);
		spm_go(16'h0280, 7'h2E, 1);
		@(posedge clk);
		wait_idle(n);
		chk(fm.cap[1], 16'hFFFF);
	endtask

	task automatic t_sect();
		int t;
		logic ok;
		for (int i = 0; i < 13; i++) begin
			dly = 32'(i);
			ok = to[i] != 3'h7;
			spm_go({tp[i], 7'h55}, tc[i], 1);
			chk({freq.req, busy}, {2{ok}});
			chk(halt, ok && (to[i] > 2 || tp[i] >= 9'h1C0));
			chk({flash_section_busy_flag, blk}, {2{ok && to[i] < 4}});
			if (ok) begin
				chk(freq.op, to[i]);
				if (to[i] < 4) chk(freq.page, tp[i]);
				t = 0;
				do begin
					@(posedge clk);
					t++;
				end while (done !== 1'b1 && t < 200);
				#1;
				chk({busy, halt}, {to[i] == 3'h5, 1'b0});
			end
			@(posedge clk);
			wait_idle(n);
		end
	endtask

	task automatic t_lpm();
		logic [7:0] e;
		for (int k = 0; k < 4; k++) begin
			wb(1, `NFS_OFS_CMD, (k < 2) ? 32'(k + 1) : 0);
			ptr <= 16'h0A40 + 16'(k);
			program_load_instruction <= 1'b1;
			@(posedge clk);
			program_load_instruction <= 1'b0;
			#1;
			e = (k == 0) ? 8'h1A : (k == 1) ? 8'h42 : (k == 2) ? 8'h42 : 8'hE6;
			chk({busy, lval, lbyte}, {2'b01, e});
			@(posedge clk);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////
	// Free running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		test_done();
	end

	// Main sequence
	initial begin
		{rst_b, cyc, stb, we, program_store_instruction, program_load_instruction, saw_h, saw_ee} = 8'h00;
		adr = 5'h00;
		wdat = 0;
		ptr = 16'h0000;
		word = 16'h0000;
		dly = 0;
		bad_count = 0;
		n_checks = 0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_regs();
		t_buf_erase();
		t_load_write();
		t_fuse_lock();
		t_sect();
		t_lpm();
		test_done();
	end
endmodule
